/* File: design/codec_fault_interrupt_logic.sv */
`timescale 1ns/100ps
module codec_fault_interrupt_logic
  import codec_irq_pkg::*;
#(
  parameter int RATIO_W = 4
) (
  input  wire logic               core_clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               clk_en_in,
  input  wire logic [7:0]         reg_addr_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  input  wire logic [7:0]         reg_wdata_in,
  output logic      [7:0]         reg_rdata_out,
  input  wire logic               test_entry_fault_in,
  input  wire logic [1:0]         serial_format_field_in,
  input  wire logic [1:0]         rate_mode_in,
  input  wire logic [RATIO_W-1:0] clock_ratio_in,
  input  wire logic               clock_error_in,
  input  wire logic [NUM_ADC-1:0] adc_power_down_in,
  input  wire logic [NUM_DAC-1:0] dac_power_down_in,
  input  wire logic [NUM_ADC-1:0] adc_overrange_in,
  input  wire logic [NUM_DAC-1:0] dac_clip_in,
  output logic                    irq_pin_out,
  output logic                    irq_pin_oe_out
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [7:0]         irq_config_reg;
  logic [7:0]         irq_mask_faults_reg;
  logic [7:0]         irq_mask_clip_reg;
  logic [7:0]         fault_flags;
  logic [NUM_DAC-1:0] dac_clip_flag;
  logic [1:0]         format_prev_reg;
  logic [1:0]         rate_prev_reg;
  logic [RATIO_W-1:0] ratio_prev_reg;
  logic               primed_reg;
  logic               powered_down;
  logic               ratio_changed;
  logic               format_changed;
  logic               serial_port_fault;
  logic               clocking_fault;
  logic [7:0]         fault_set;
  logic [7:0]         fault_clr;
  logic [NUM_DAC-1:0] clip_clr;
  logic               wr_fire;
  logic               rd_fire;
  logic               rd_faults;
  logic               rd_clip;
  logic               auto_mask;
  logic               irq_active;
  drive_mode_t        irq_pin_drive_mode;

  // ------------------------------------------------------------------
  // Control port strobes
  // ------------------------------------------------------------------
  // Write has priority when both strobes are high
  assign wr_fire   = clk_en_in & reg_wr_in;
  assign rd_fire   = clk_en_in & reg_rd_in & ~reg_wr_in;
  assign rd_faults = rd_fire & (reg_addr_in == ADDR_IRQ_FLAGS_FAULTS);
  assign rd_clip   = rd_fire & (reg_addr_in == ADDR_IRQ_FLAGS_CLIP);

  // ------------------------------------------------------------------
  // Configuration fields
  // ------------------------------------------------------------------
  // Config field split
  assign auto_mask          = ~irq_config_reg[CFG_AUTOMASK_BIT];
  assign irq_pin_drive_mode = irq_config_reg[CFG_DRIVE_MSB:CFG_DRIVE_LSB];

  // Configuration register, reserved bits held at zero
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_config_reg <= IRQ_CONFIG_RST;
    end else if (wr_fire && reg_addr_in == ADDR_IRQ_CONFIG) begin
      irq_config_reg <= reg_wdata_in & CONFIG_WR_BITS;
    end
  end

  // ------------------------------------------------------------------
  // Mask registers
  // ------------------------------------------------------------------
  // Fault mask layout, bit 4 reserved
  // Auto-mask of flags returned by a read
  // Masks change only by writes when auto-mask is off
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_mask_faults_reg <= IRQ_MASK_RST;
    end else if (wr_fire && reg_addr_in == ADDR_IRQ_MASK_FAULTS) begin
      irq_mask_faults_reg <= reg_wdata_in & FAULT_BITS;
    end else if (rd_faults && auto_mask) begin
      irq_mask_faults_reg <= irq_mask_faults_reg | (fault_flags & FAULT_BITS);
    end
  end

  // Clip mask layout, bits 7:5 reserved
  // Auto-mask of clip flags returned by a read
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_mask_clip_reg <= IRQ_MASK_RST;
    end else if (wr_fire && reg_addr_in == ADDR_IRQ_MASK_CLIP) begin
      irq_mask_clip_reg <= reg_wdata_in & CLIP_BITS;
    end else if (rd_clip && auto_mask) begin
      irq_mask_clip_reg <= irq_mask_clip_reg
                         | {{(8-NUM_DAC){1'b0}}, dac_clip_flag};
    end
  end

  // ------------------------------------------------------------------
  // Setting change detection
  // ------------------------------------------------------------------
  // Previous values; the first enabled cycle after reset only primes them
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      format_prev_reg <= 2'h0;
      rate_prev_reg   <= 2'h0;
      ratio_prev_reg  <= '0;
      primed_reg      <= 1'b0;
    end else if (clk_en_in) begin
      format_prev_reg <= serial_format_field_in;
      rate_prev_reg   <= rate_mode_in;
      ratio_prev_reg  <= clock_ratio_in;
      primed_reg      <= 1'b1;
    end
  end

  // Powered down only with every converter off
  assign powered_down = (&adc_power_down_in) & (&dac_power_down_in);

  assign format_changed = primed_reg
                        & ((serial_format_field_in != format_prev_reg)
                        | (rate_mode_in != rate_prev_reg));
  assign ratio_changed  = primed_reg & (clock_ratio_in != ratio_prev_reg);

  // Serial port fault on format or rate change while powered
  // Ratio change while powered raises both faults
  // Host is expected to power down first; nothing blocks the change
  assign serial_port_fault = ~powered_down & (format_changed | ratio_changed);
  assign clocking_fault    = clock_error_in | (~powered_down & ratio_changed);

  // ------------------------------------------------------------------
  // Sticky flags
  // ------------------------------------------------------------------
  // Test entry fault raised by its event
  // Flag layout with bit 4 reserved
  assign fault_set = {test_entry_fault_in, serial_port_fault,
                      clocking_fault, 1'b0, adc_overrange_in};

  // A read clears exactly the flags it returned
  assign fault_clr = rd_faults ? fault_flags : 8'h00;
  assign clip_clr  = rd_clip ? dac_clip_flag : '0;

  // Sticky until cleared by a read
  // Serial port flag holds until cleared
  sticky_flag_bank #(
    .WIDTH       (8)
  ) u_fault_flags (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .clk_en_in   (clk_en_in),
    .set_in      (fault_set),
    .clr_in      (fault_clr),
    .flags_out   (fault_flags)
  );

  sticky_flag_bank #(
    .WIDTH       (NUM_DAC)
  ) u_clip_flags (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .clk_en_in   (clk_en_in),
    .set_in      (dac_clip_in),
    .clr_in      (clip_clr),
    .flags_out   (dac_clip_flag)
  );

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  // Registered read data, one cycle after the read strobe
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= READ_ZERO;
    end else if (rd_fire) begin
      case (reg_addr_in)
        ADDR_IRQ_CONFIG:       reg_rdata_out <= irq_config_reg;
        ADDR_IRQ_MASK_FAULTS:  reg_rdata_out <= irq_mask_faults_reg;
        ADDR_IRQ_MASK_CLIP:    reg_rdata_out <= irq_mask_clip_reg;
        ADDR_IRQ_FLAGS_FAULTS: reg_rdata_out <= fault_flags & FAULT_BITS;
        ADDR_IRQ_FLAGS_CLIP: begin
          reg_rdata_out <= {{(8-NUM_DAC){1'b0}}, dac_clip_flag};
        end
        default:               reg_rdata_out <= READ_ZERO;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Interrupt pin
  // ------------------------------------------------------------------
  // Mask bit 1 blocks, 0 passes
  // Any unmasked set flag asserts the pin, except in the reserved drive mode, which releases it
  assign irq_active =
      (|(fault_flags & ~irq_mask_faults_reg & FAULT_BITS))
    | (|(dac_clip_flag & ~irq_mask_clip_reg[NUM_DAC-1:0]));

  irq_pin_driver u_pin (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .clk_en_in   (clk_en_in),
    .active_in   (irq_active),
    .mode_in     (irq_pin_drive_mode),
    .pin_out     (irq_pin_out),
    .pin_oe_out  (irq_pin_oe_out)
  );

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_test_entry_sets: assert property (
    clk_en_in && test_entry_fault_in |=> fault_flags[FLT_TEST_BIT])
    else $error("test entry fault not latched");

  a_adc_flag_latch: assert property (
    clk_en_in && adc_overrange_in[0] ##1 !rd_faults[*2]
      |-> fault_flags[0])
    else $error("adc overrange flag lost");

  a_format_fault: assert property (
    clk_en_in && primed_reg && !powered_down
      && serial_format_field_in != format_prev_reg
      |=> fault_flags[FLT_SERIAL_BIT])
    else $error("format change did not raise serial fault");

  // No serial fault while powered down
  a_quiet_powered_down: assert property (
    clk_en_in && powered_down && !fault_flags[FLT_SERIAL_BIT]
      |=> !fault_flags[FLT_SERIAL_BIT])
    else $error("serial fault raised while powered down");

  a_ratio_both: assert property (
    clk_en_in && primed_reg && !powered_down
      && clock_ratio_in != ratio_prev_reg
      |=> fault_flags[FLT_SERIAL_BIT] && fault_flags[FLT_CLOCK_BIT])
    else $error("ratio change missed a fault");

  // Serial flag holds without a read
  a_serial_holds: assert property (
    fault_flags[FLT_SERIAL_BIT] && !rd_faults
      |=> fault_flags[FLT_SERIAL_BIT])
    else $error("serial fault flag dropped without read");

  a_read_returns: assert property (
    rd_faults |=> reg_rdata_out == ($past(fault_flags) & FAULT_BITS))
    else $error("flag read returned wrong data");

  a_read_clears: assert property (
    rd_faults && fault_set == 8'h00 |=> fault_flags == 8'h00)
    else $error("read did not clear flags");

  a_set_wins: assert property (
    rd_faults && clocking_fault |=> fault_flags[FLT_CLOCK_BIT])
    else $error("event lost in read cycle");

  a_auto_mask: assert property (
    rd_faults && auto_mask
      |=> (irq_mask_faults_reg & $past(fault_flags) & FAULT_BITS)
          == ($past(fault_flags) & FAULT_BITS))
    else $error("auto-mask did not set mask bits");

  // Fault mask holds when auto-mask is off
  a_mask_hold: assert property (
    !auto_mask && !(wr_fire && reg_addr_in == ADDR_IRQ_MASK_FAULTS)
      |=> $stable(irq_mask_faults_reg))
    else $error("mask changed without a write");

  // Active-high pin follows the unmasked flags
  a_pin_high: assert property (
    clk_en_in && irq_pin_drive_mode == DRIVE_ACT_HIGH
      |=> irq_pin_oe_out && irq_pin_out == $past(irq_active))
    else $error("active-high pin mismatch");

  // Open drain pulls low only while active
  a_pin_open_drain: assert property (
    clk_en_in && irq_pin_drive_mode == DRIVE_OPEN_LOW
      |=> !irq_pin_out && irq_pin_oe_out == $past(irq_active))
    else $error("open-drain pin mismatch");

  // Fully masked flags keep the pin quiet
  a_mask_blocks: assert property (
    irq_mask_faults_reg == FAULT_BITS && irq_mask_clip_reg == CLIP_BITS
      |-> !irq_active)
    else $error("masked flag asserted the pin");

  c_auto_mask_read: cover property (
    rd_faults && auto_mask && fault_flags != 8'h00);
  c_ratio_fault: cover property (
    clk_en_in && primed_reg && !powered_down && ratio_changed);
  c_open_drain_low: cover property (
    irq_pin_drive_mode == DRIVE_OPEN_LOW && irq_pin_oe_out);
  c_clip_read: cover property (rd_clip && dac_clip_flag != '0);

endmodule : codec_fault_interrupt_logic

/* File: design/codec_irq_pkg.sv */
package codec_irq_pkg;

  // ------------------------------------------------------------------
  // Register offsets on the control port
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_CONFIG       = 8'h1E;
  localparam logic [7:0] ADDR_IRQ_MASK_FAULTS  = 8'h1F;
  localparam logic [7:0] ADDR_IRQ_MASK_CLIP    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_FLAGS_FAULTS = 8'h21;
  localparam logic [7:0] ADDR_IRQ_FLAGS_CLIP   = 8'h22;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CFG_AUTOMASK_BIT = 7;
  localparam int CFG_DRIVE_MSB    = 6;
  localparam int CFG_DRIVE_LSB    = 5;
  localparam int FLT_TEST_BIT     = 7;
  localparam int FLT_SERIAL_BIT   = 6;
  localparam int FLT_CLOCK_BIT    = 5;
  localparam int NUM_ADC          = 4;
  localparam int NUM_DAC          = 5;

  // ------------------------------------------------------------------
  // Reset values and writable bits (reserved bits read as zero)
  // ------------------------------------------------------------------
  localparam logic [7:0] IRQ_CONFIG_RST  = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST    = 8'h00;
  localparam logic [7:0] CONFIG_WR_BITS  = 8'hE0;
  localparam logic [7:0] FAULT_BITS      = 8'hEF;
  localparam logic [7:0] CLIP_BITS       = 8'h1F;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // ------------------------------------------------------------------
  // Interrupt pin drive modes
  // ------------------------------------------------------------------
  typedef logic [1:0] drive_mode_t;
  localparam drive_mode_t DRIVE_ACT_HIGH  = 2'h0;
  localparam drive_mode_t DRIVE_ACT_LOW   = 2'h1;
  localparam drive_mode_t DRIVE_OPEN_LOW  = 2'h2;
  localparam drive_mode_t DRIVE_RESERVED  = 2'h3;

endpackage : codec_irq_pkg

/* File: design/irq_pin_driver.sv */
`timescale 1ns/100ps
module irq_pin_driver
  import codec_irq_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  input  wire logic        active_in,
  input  wire drive_mode_t mode_in,
  output logic             pin_out,
  output logic             pin_oe_out
);

  // ------------------------------------------------------------------
  // Registered pin levels per drive mode
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_out    <= 1'b0;
      pin_oe_out <= 1'b1;
    end else if (clk_en_in) begin
      case (mode_in)
        DRIVE_ACT_HIGH: begin
          pin_out    <= active_in;
          pin_oe_out <= 1'b1;
        end
        DRIVE_ACT_LOW: begin
          pin_out    <= ~active_in;
          pin_oe_out <= 1'b1;
        end
        DRIVE_OPEN_LOW: begin
          pin_out    <= 1'b0;
          pin_oe_out <= active_in;  // Pull low only when active
        end
        default: begin
          pin_out    <= 1'b0;       // Reserved code releases the pin
          pin_oe_out <= 1'b0;
        end
      endcase
    end
  end

endmodule : irq_pin_driver

/* File: design/sticky_flag_bank.sv */
`timescale 1ns/100ps
module sticky_flag_bank
  import codec_irq_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output logic      [WIDTH-1:0] flags_out
);

  // ------------------------------------------------------------------
  // One sticky bit per entry, set beats clear
  // ------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          flags_out[i] <= 1'b0;
        end else if (clk_en_in) begin
          if (set_in[i]) begin
            flags_out[i] <= 1'b1;
          end else if (clr_in[i]) begin
            flags_out[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule : sticky_flag_bank

/* File: sim/host_model.sv */
`timescale 1ns/100ps
module host_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       irq_pin_in,
  input  wire logic       irq_pin_oe_in,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic            irq_level_out
);
  // Board pull-up: a released pin reads high
  assign irq_level_out = irq_pin_oe_in ? irq_pin_in : 1'b1;

  // Bus idle at time zero
  initial begin
    reg_addr_out  = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end

  // One strobe cycle; address and data scrambled once released
  task automatic access(input logic [7:0] a, input logic [7:0] d,
                        input logic wr, output logic [7:0] q);
    @(posedge core_clk_in);
    #1;
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_out    = wr;
    reg_rd_out    = ~wr;
    @(posedge core_clk_in);
    #1;
    q             = reg_rdata_in;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_addr_out  = ~a;
    reg_wdata_out = ~d;
  endtask : access

  // Register write
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] unused;
    access(a, d, 1'b1, unused);
  endtask : write_reg

  // Register read, data taken one cycle after the strobe edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
    access(a, 8'h00, 1'b0, q);
  endtask : read_reg
endmodule : host_model

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
// Compare, count and report
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end end
module tb_top;
  typedef struct packed {
    logic [10:0] ev;
    logic [7:0]  addr;
    logic [7:0]  exp;
  } row_t;

  logic       core_clk_in = 1'b0;
  logic       sys_rst_in  = 1'b1;
  logic       clk_en_in   = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_data;
  logic       reg_wr, reg_rd, irq_pin, irq_oe, irq_level;
  logic       test_ev     = 1'b0;
  logic       clk_ev      = 1'b0;
  logic [3:0] adc_ev      = 4'h0;
  logic [4:0] dac_ev      = 5'h00;
  logic [1:0] fmt         = 2'h0;
  logic [1:0] rate        = 2'h0;
  logic [3:0] ratio       = 4'h0;
  logic [8:0] pdn         = 9'h000;
  int         num_errors  = 0;
  int         n_tests     = 0;
  // Event rows: {test, clock, adc[3:0], dac[4:0]}, flag register, value
  row_t       rows [6]    = '{'{11'h400, 8'h21, 8'h80},
    '{11'h200, 8'h21, 8'h20}, '{11'h020, 8'h21, 8'h01},
    '{11'h100, 8'h21, 8'h08}, '{11'h001, 8'h22, 8'h01},
    '{11'h010, 8'h22, 8'h10}};
  logic [7:0] acc_a [5]   = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h30};
  logic [7:0] acc_e [5]   = '{8'hE0, 8'hEF, 8'h1F, 8'h00, 8'h00};
  // Pin {out, oe, wire} per mode, flag pending and idle
  logic [2:0] act_e [4]   = '{3'b111, 3'b010, 3'b010, 3'b001};
  logic [2:0] idle_e [4]  = '{3'b010, 3'b111, 3'b001, 3'b001};

  always #20 core_clk_in = ~core_clk_in;

  codec_fault_interrupt_logic uut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
    .test_entry_fault_in(test_ev), .serial_format_field_in(fmt),
    .rate_mode_in(rate), .clock_ratio_in(ratio),
    .clock_error_in(clk_ev), .adc_power_down_in(pdn[8:5]),
    .dac_power_down_in(pdn[4:0]), .adc_overrange_in(adc_ev),
    .dac_clip_in(dac_ev), .irq_pin_out(irq_pin),
    .irq_pin_oe_out(irq_oe)
  );

  host_model host (
    .core_clk_in(core_clk_in), .reg_rdata_in(reg_rdata),
    .irq_pin_in(irq_pin), .irq_pin_oe_in(irq_oe),
    .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
    .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .irq_level_out(irq_level)
  );

  // Verdict and end of run
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // Wait n edges, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick

  // One-cycle event pulse
  task automatic pulse(input logic [10:0] ev);
    tick(1);
    {test_ev, clk_ev, adc_ev, dac_ev} = ev;
    tick(1);
    {test_ev, clk_ev, adc_ev, dac_ev} = 11'h000;
  endtask : pulse

  // Read a register and compare
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.read_reg(a, rd_data);
    `CHK($sformatf("reg %h", a), e, rd_data)
  endtask : rd_chk

  // Compare pin output, enable and resolved wire
  task automatic pin_chk(input logic [2:0] e);
    `CHK("irq pin", e, {irq_pin, irq_oe, irq_level})
  endtask : pin_chk

  // Change power-down and clocking settings, then read faults
  task automatic lvl(input logic [8:0] p, input logic [1:0] f,
                     input logic [1:0] r, input logic [3:0] q,
                     input logic [7:0] e);
    tick(1);
    {pdn, fmt, rate, ratio} = {p, f, r, q};
    tick(2);
    rd_chk(8'h21, e);
  endtask : lvl

  // Watchdog
  initial begin
    #800000;
    num_errors++;
    end_of_test();
  end

  initial begin
    tick(6);
    sys_rst_in = 1'b0;
    pin_chk(3'b010);
    for (logic [7:0] a = 8'h1E; a <= 8'h22; a++) begin
      rd_chk(a, 8'h00);
    end
    // Access kinds and reserved bits
    for (int i = 0; i < 5; i++) begin
      host.write_reg(acc_a[i], 8'hFF);
      rd_chk(acc_a[i], acc_e[i]);
    end
    host.write_reg(8'h1E, 8'h80);
    host.write_reg(8'h1F, 8'h00);
    host.write_reg(8'h20, 8'h00);
    // Event table: latch, pin, clear on read
    for (int i = 0; i < 6; i++) begin
      pulse(rows[i].ev);
      tick(1);
      pin_chk(3'b111);
      rd_chk(rows[i].addr, rows[i].exp);
      rd_chk(rows[i].addr, 8'h00);
      pin_chk(3'b010);
    end
    rd_chk(8'h1F, 8'h00);
    rd_chk(8'h20, 8'h00);
    host.write_reg(8'h1F, 8'h01);
    host.write_reg(8'h20, 8'h1F);
    pulse(11'h03F);
    tick(1);
    pin_chk(3'b010);
    rd_chk(8'h21, 8'h01);
    rd_chk(8'h22, 8'h1F);
    host.write_reg(8'h1F, 8'h00);
    host.write_reg(8'h20, 8'h00);
    host.write_reg(8'h1E, 8'h00);
    pulse(11'h088);
    rd_chk(8'h21, 8'h04);
    rd_chk(8'h1F, 8'h04);
    rd_chk(8'h22, 8'h08);
    rd_chk(8'h20, 8'h08);
    host.write_reg(8'h1F, 8'h00);
    host.write_reg(8'h20, 8'h00);
    pulse(11'h020);
    for (int m = 0; m < 4; m++) begin
      host.write_reg(8'h1E, {1'b1, m[1:0], 5'h00});
      tick(1);
      pin_chk(act_e[m]);
    end
    rd_chk(8'h21, 8'h01);
    for (int m = 0; m < 4; m++) begin
      host.write_reg(8'h1E, {1'b1, m[1:0], 5'h00});
      tick(1);
      pin_chk(idle_e[m]);
    end
    host.write_reg(8'h1E, 8'h80);
    fork
      host.read_reg(8'h21, rd_data);
      pulse(11'h040);
    join
    `CHK("same cycle read", 8'h00, rd_data)
    rd_chk(8'h21, 8'h02);
    lvl(9'h000, 2'h1, 2'h0, 4'h0, 8'h40);
    lvl(9'h000, 2'h1, 2'h2, 4'h0, 8'h40);
    lvl(9'h000, 2'h1, 2'h2, 4'h3, 8'h60);
    lvl(9'h1FF, 2'h2, 2'h1, 4'h5, 8'h00);
    lvl(9'h1EF, 2'h3, 2'h1, 4'h5, 8'h40);
    // Frozen clock enable ignores events
    tick(1);
    clk_en_in = 1'b0;
    pulse(11'h100);
    clk_en_in = 1'b1;
    rd_chk(8'h21, 8'h00);
    // Reset in mid-run
    pulse(11'h200);
    sys_rst_in = 1'b1;
    tick(2);
    sys_rst_in = 1'b0;
    pin_chk(3'b010);
    rd_chk(8'h21, 8'h00);
    end_of_test();
  end
endmodule : tb_top
